// ### src/ttd_cfg.svh
`ifndef TTD_CFG_SVH
`define TTD_CFG_SVH

// width of the raw charge-transfer count
`define TTD_SIG_W        16
// per-burst reference slew limits; downward is the faster direction
`define TTD_UP_STEP      16'h0001
`define TTD_DN_STEP      16'h0008
// threshold fraction of the signal, as a right shift (bigger shift, smaller fraction)
`define TTD_SHIFT_HIGH   4'h5
`define TTD_SHIFT_MED    4'h4
`define TTD_SHIFT_LOW    4'h3
// consecutive detecting bursts needed before the output asserts
`define TTD_INTEG_COUNT  3'h4
// reset values
`define TTD_REF_RST      16'h0000
`define TTD_CNT_RST      3'h0

`endif

// ### src/ttd_pkg.sv
`include "ttd_cfg.svh"

package ttd_pkg;

  // one measurement per acquisition burst
  typedef struct packed {
    logic                 valid;
    logic [`TTD_SIG_W-1:0] level;
  } ttd_burst_s;

  // what the strap front end sees on the gain pin
  typedef struct packed {
    logic tied_a;  // strap tied to sense_terminal_a
    logic tied_b;  // strap tied to sense_terminal_b
  } ttd_strap_s;

  typedef enum logic [1:0] {
    TTD_GAIN_HIGH,
    TTD_GAIN_MED,
    TTD_GAIN_LOW
  } ttd_gain_e;

  typedef enum logic [1:0] {
    TTD_ST_STRAP,
    TTD_ST_CAL,
    TTD_ST_TRACK
  } ttd_state_e;

endpackage : ttd_pkg

// ### src/ttd_integrator.sv
`timescale 1ns/1ps
`default_nettype none
`include "ttd_cfg.svh"

module ttd_integrator (
  input  wire logic       clk,     // system clock
  input  wire logic       rst_n,   // async reset, active low
  input  wire logic       burst,   // one-cycle pulse, a burst result is ready
  input  wire logic       hit,     // that burst detected
  output logic            active,  // sensor output, registered
  output logic [2:0]      count    // consecutive detecting bursts
);
  import ttd_pkg::*;

  logic [2:0] next_count;
  logic       next_active;

  // consensus filter: climb on each hit up to four, drop to zero on any miss
  always_comb begin
    next_count  = count;
    next_active = active;
    if (burst) begin
      if (!hit) begin
        next_count = `TTD_CNT_RST;
      end else if (count != `TTD_INTEG_COUNT) begin
        next_count = count + 3'h1;
      end
      next_active = hit && (next_count == `TTD_INTEG_COUNT);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count  <= `TTD_CNT_RST;
      active <= 1'b0;
    end else begin
      count  <= next_count;
      active <= next_active;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  integ_full_a: assert property (active |-> count == 3'h4)
    else $error("output active before four detecting bursts");
  integ_miss_a: assert property (burst && !hit |=> !active && count == 3'h0)
    else $error("integrator not cleared by a missed burst");
  cover_touch_c: cover property (!active ##1 active);

endmodule : ttd_integrator

`default_nettype wire

// ### src/ttd_tracker.sv
`timescale 1ns/1ps
`default_nettype none
// steps, shifts and widths shared with the integrator and the bench
`include "ttd_cfg.svh"

module ttd_tracker (
  input  wire logic                   SYS_CLK,     // 10 MHz system clock
  input  wire logic                   RST_N,       // power-on reset, async, active low
  input  wire ttd_pkg::ttd_burst_s    BURST,       // raw measurement per burst
  input  wire ttd_pkg::ttd_strap_s    GAIN_STRAP,  // gain pin strap sense
  output ttd_pkg::ttd_gain_e          GAIN_LEVEL,  // latched gain
  output logic                        READY,       // reference calibrated
  output logic [`TTD_SIG_W-1:0]       REFERENCE,   // tracked reference
  output logic                        RAW_DETECT,  // per-burst detect with hysteresis
  output logic                        TOUCH_OUT    // integrated sensor output
);
  import ttd_pkg::*;

  localparam int W = `TTD_SIG_W;

  ttd_state_e     state;
  ttd_state_e     next_state;
  ttd_gain_e      next_gain;
  logic [W-1:0]   next_ref;
  logic           next_det;
  logic           next_ready;
  logic           burst_done;
  logic           next_burst_done;

  logic [3:0]     shift;
  logic [W-1:0]   delta;
  logic [W:0]     thr;
  logic [W:0]     drop;
  logic [W:0]     sig_x;
  logic [W:0]     ref_x;
  logic [W-1:0]   diff_up;
  logic [W-1:0]   diff_dn;

  // gain acts only here, on the offset; the measurement itself is never touched
  always_comb begin
    case (GAIN_LEVEL)
      TTD_GAIN_HIGH: shift = `TTD_SHIFT_HIGH;
      TTD_GAIN_MED:  shift = `TTD_SHIFT_MED;
      TTD_GAIN_LOW:  shift = `TTD_SHIFT_LOW;
      default:       shift = `TTD_SHIFT_HIGH;
    endcase
  end

  // threshold and dropout rebuilt from the live signal and reference each burst,
  // so a drifting capacitor never leaves a stale threshold behind;
  // the sums are one bit wider than the count, so a high reference cannot wrap
  always_comb begin
    sig_x   = {1'b0, BURST.level};
    ref_x   = {1'b0, REFERENCE};
    delta   = BURST.level >> shift;
    thr     = ref_x + {1'b0, delta};
    drop    = ref_x + {2'b00, delta[W-1:1]};
    diff_up = BURST.level - REFERENCE;
    diff_dn = REFERENCE - BURST.level;
  end

  // sequencing: catch the strap, take a first reference, then track
  always_comb begin
    next_state      = state;
    next_gain       = GAIN_LEVEL;
    next_ref        = REFERENCE;
    next_det        = RAW_DETECT;
    next_ready      = READY;
    next_burst_done = 1'b0;
    case (state)
      TTD_ST_STRAP: begin
        // one look only; a re-strapped pin waits for the next power cycle
        if (GAIN_STRAP.tied_a) begin
          next_gain = TTD_GAIN_MED;
        end else if (GAIN_STRAP.tied_b) begin
          next_gain = TTD_GAIN_LOW;
        end else begin
          next_gain = TTD_GAIN_HIGH;
        end
        next_state = TTD_ST_CAL;
      end
      TTD_ST_CAL: begin
        if (BURST.valid) begin
          next_ref   = BURST.level;
          next_ready = 1'b1;
          next_state = TTD_ST_TRACK;
        end
      end
      TTD_ST_TRACK: begin
        if (BURST.valid) begin
          next_burst_done = 1'b1;
          if (RAW_DETECT) begin
            // reference held; only the dropout level can end the detection
            if (sig_x < drop) begin
              next_det = 1'b0;
            end
          end else if (sig_x > thr) begin
            next_det = 1'b1;
          end else if (BURST.level > REFERENCE) begin
            // slow upward creep so an approaching finger is not absorbed
            next_ref = (diff_up > `TTD_UP_STEP) ? REFERENCE + `TTD_UP_STEP
                                                : BURST.level;
          end else if (BURST.level < REFERENCE) begin
            // faster downward pull recovers from a removed obstruction
            next_ref = (diff_dn > `TTD_DN_STEP) ? REFERENCE - `TTD_DN_STEP
                                                : BURST.level;
          end
        end
      end
      default: begin
        next_state = TTD_ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state      <= TTD_ST_STRAP;
      GAIN_LEVEL <= TTD_GAIN_HIGH;
      REFERENCE  <= `TTD_REF_RST;
      RAW_DETECT <= 1'b0;
      READY      <= 1'b0;
      burst_done <= 1'b0;
    end else begin
      state      <= next_state;
      GAIN_LEVEL <= next_gain;
      REFERENCE  <= next_ref;
      RAW_DETECT <= next_det;
      READY      <= next_ready;
      burst_done <= next_burst_done;
    end
  end

  // consensus filter sees each burst one cycle later, after the detect flag settles
  ttd_integrator ttd_integrator_inst (
    .clk    (SYS_CLK),
    .rst_n  (RST_N),
    .burst  (burst_done),
    .hit    (RAW_DETECT),
    .active (TOUCH_OUT),
    .count  ()
  );

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  ref_hold_a: assert property (state == TTD_ST_TRACK && RAW_DETECT |=> $stable(REFERENCE))
    else $error("reference moved during a detection");
  // full steps are checked only where the step, not the gap, limits the move
  up_step_a: assert property (state == TTD_ST_TRACK && BURST.valid && !RAW_DETECT
      && sig_x <= thr && BURST.level > REFERENCE + `TTD_UP_STEP
      |=> REFERENCE == $past(REFERENCE) + `TTD_UP_STEP)
    else $error("upward tracking step wrong");
  down_step_a: assert property (state == TTD_ST_TRACK && BURST.valid && !RAW_DETECT
      && REFERENCE > BURST.level + `TTD_DN_STEP
      |=> REFERENCE == $past(REFERENCE) - `TTD_DN_STEP)
    else $error("downward tracking step wrong");

  // gain capture is one-shot; a re-strapped pin must not leak through
  gain_lock_a: assert property (state != TTD_ST_STRAP |=> $stable(GAIN_LEVEL))
    else $error("gain changed after strap capture");
  open_high_a: assert property (state == TTD_ST_STRAP && !GAIN_STRAP.tied_a
      && !GAIN_STRAP.tied_b |=> GAIN_LEVEL == TTD_GAIN_HIGH)
    else $error("open strap did not give high gain");

  // hysteresis: set above the threshold, clear only below the dropout level
  detect_set_a: assert property (state == TTD_ST_TRACK && BURST.valid && sig_x > thr
      |=> RAW_DETECT)
    else $error("signal above threshold not detected");
  dropout_a: assert property (state == TTD_ST_TRACK && BURST.valid && RAW_DETECT
      && sig_x >= drop |=> RAW_DETECT)
    else $error("detection ended above dropout level");
  release_a: assert property (state == TTD_ST_TRACK && BURST.valid && RAW_DETECT
      && sig_x < drop |=> !RAW_DETECT ##1 !TOUCH_OUT)
    else $error("detection did not end below dropout");

  // the two ties land on their own gains; both tied falls to medium
  strap_med_a: assert property (state == TTD_ST_STRAP && GAIN_STRAP.tied_a
      |=> GAIN_LEVEL == TTD_GAIN_MED)
    else $error("strap tie a did not give medium gain");
  strap_low_a: assert property (state == TTD_ST_STRAP && !GAIN_STRAP.tied_a
      && GAIN_STRAP.tied_b |=> GAIN_LEVEL == TTD_GAIN_LOW)
    else $error("strap tie b did not give low gain");

  // first accepted burst seeds the reference so tracking starts from the real signal
  cal_ref_a: assert property (state == TTD_ST_CAL && BURST.valid
      |=> READY && REFERENCE == $past(BURST.level))
    else $error("calibration burst did not seed the reference");

  // a crossing burst starts a detection and must not nudge the reference as well
  cross_hold_a: assert property (state == TTD_ST_TRACK && BURST.valid && !RAW_DETECT
      && sig_x > thr |=> $stable(REFERENCE))
    else $error("reference moved on a detecting burst");

  // a gap smaller than one step closes exactly, with no overshoot past the signal
  up_land_a: assert property (state == TTD_ST_TRACK && BURST.valid && !RAW_DETECT
      && sig_x <= thr && BURST.level > REFERENCE && diff_up <= `TTD_UP_STEP
      |=> REFERENCE == $past(BURST.level))
    else $error("upward tracking overshot a small gap");
  down_land_a: assert property (state == TTD_ST_TRACK && BURST.valid && !RAW_DETECT
      && BURST.level < REFERENCE && diff_dn <= `TTD_DN_STEP
      |=> REFERENCE == $past(BURST.level))
    else $error("downward tracking overshot a small gap");

  cover_cal_c:  cover property (state == TTD_ST_CAL ##1 state == TTD_ST_TRACK);
  cover_med_c:  cover property (state == TTD_ST_STRAP && GAIN_STRAP.tied_a);
  cover_low_c:  cover property (state == TTD_ST_STRAP && GAIN_STRAP.tied_b && !GAIN_STRAP.tied_a);
  cover_drop_c: cover property (RAW_DETECT ##1 !RAW_DETECT);

endmodule : ttd_tracker

`default_nettype wire

// ### verification/tb_ttd_tracker.sv
`timescale 1ns/1ps
`default_nettype none

`include "ttd_cfg.svh"

module tb_ttd_tracker;
  import ttd_pkg::*;

  logic       sys_clk;
  logic       rst_n;
  ttd_burst_s burst;
  ttd_strap_s strap;
  ttd_gain_e  gain_level;
  logic       ready;
  logic [15:0] reference;
  logic       raw_detect;
  logic       touch_out;
  int         failures;
  int         checks;

  ttd_tracker ttd_tracker_inst (
    .SYS_CLK    (sys_clk),
    .RST_N      (rst_n),
    .BURST      (burst),
    .GAIN_STRAP (strap),
    .GAIN_LEVEL (gain_level),
    .READY      (ready),
    .REFERENCE  (reference),
    .RAW_DETECT (raw_detect),
    .TOUCH_OUT  (touch_out)
  );

  // 100 ns period
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_val(name, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one burst, then the results once every output has settled
  task automatic do_burst(input logic [15:0] lvl, input logic raw, input logic [15:0] rf,
                          input logic tch);
    burst = '{valid: 1'b1, level: lvl};
    @(posedge sys_clk) #10;
    burst.valid = 1'b0;
    repeat (2) @(posedge sys_clk);
    #10;
    chk_bit("ready", 1'b1, ready);
    chk_bit("raw_detect", raw, raw_detect);
    chk_val("reference", rf, reference);
    chk_bit("touch_out", tch, touch_out);
  endtask

  // reset with a strap, a burst the design must drop, move the strap, then calibrate
  task automatic start(input ttd_strap_s s, input ttd_gain_e g);
    rst_n = 1'b0;
    strap = s;
    repeat (4) @(posedge sys_clk);
    #10;
    chk_bit("ready", 1'b0, ready);
    chk_val("reference", 16'h0000, reference);
    chk_bit("raw_detect", 1'b0, raw_detect);
    chk_bit("touch_out", 1'b0, touch_out);
    rst_n = 1'b1;
    burst = '{valid: 1'b1, level: 16'h0200};
    @(posedge sys_clk) #10;
    strap = ~s;
    burst.valid = 1'b0;
    repeat (2) @(posedge sys_clk);
    #10;
    chk_bit("ready", 1'b0, ready); // first edge burst ignored
    chk_val("gain", {14'h0000, g}, {14'h0000, gain_level});
    do_burst(16'h0400, 1'b0, 16'h0400, 1'b0);
  endtask

  // every strap code, same signal, detect decided by the gain's fraction alone
  task automatic test_gain();
    ttd_strap_s s [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
    ttd_gain_e  g [4] = '{TTD_GAIN_HIGH, TTD_GAIN_MED, TTD_GAIN_LOW, TTD_GAIN_MED};
    logic [3:0] sh [4] = '{`TTD_SHIFT_HIGH, `TTD_SHIFT_MED, `TTD_SHIFT_LOW, `TTD_SHIFT_MED};
    logic       det;
    for (int i = 0; i < 4; i++) begin
      start(s[i], g[i]);
      det = 16'd1080 > 16'd1024 + (16'd1080 >> sh[i]);
      do_burst(16'd1080, det, det ? 16'd1024 : 16'd1024 + `TTD_UP_STEP, 1'b0);
    end
  endtask

  // slow creep up, faster pull down, exact landing on a small gap, then a crossing:
  // the delta comes from the signal, 1048 >> 5 = 32, so the threshold sits at 1046
  task automatic test_track();
    start(2'b00, TTD_GAIN_HIGH);
    do_burst(16'd1030, 1'b0, 16'd1024 + `TTD_UP_STEP, 1'b0);
    do_burst(16'd900, 1'b0, 16'd1025 - `TTD_DN_STEP, 1'b0);
    do_burst(16'd1014, 1'b0, 16'd1014, 1'b0);
    do_burst(16'd1048, 1'b1, 16'd1014, 1'b0);
  endtask

  // hysteresis, frozen reference and the four-burst filter
  task automatic test_detect();
    start(2'b00, TTD_GAIN_HIGH);
    // threshold 1024 + 32 = 1056 lets 1050 only creep; dropout is 1025 + 16 = 1041
    do_burst(16'd1050, 1'b0, 16'd1025, 1'b0);
    do_burst(16'd1200, 1'b1, 16'd1025, 1'b0);
    do_burst(16'd1050, 1'b1, 16'd1025, 1'b0);
    do_burst(16'd1041, 1'b1, 16'd1025, 1'b0);
    do_burst(16'd1040, 1'b0, 16'd1025, 1'b0);
    for (int i = 1; i <= 4; i++) begin
      do_burst(16'd1200, 1'b1, 16'd1025, i == 4);
    end
    do_burst(16'd1200, 1'b1, 16'd1025, 1'b1);
    do_burst(16'd900, 1'b0, 16'd1025, 1'b0);
  endtask

  // stimulus
  initial begin
    failures = 0;
    checks = 0;
    rst_n = 1'b0;
    burst = '0;
    strap = '0;
    test_gain();
    test_track();
    test_detect();
    stop_test();
  end

  // the tests need well under 200 bursts of a few cycles each
  initial begin
    #(100 * 2000);
    failures++;
    stop_test();
  end

endmodule // tb_ttd_tracker

`default_nettype wire
